/* src/pmrs_sequencer.sv */
// Power-mode and reset sequencer, always-on timer, retention registers and clock output divider.
// Assumes sys_clk is the always-on clock; pins arrive asynchronous and are synchronised here.
// Summary of operation
// - After a system reset completes, enter deep sleep until a pin, USB or timer wake.
// - Shutdown only by software write; only a wake pin level revives it.
// - Deep sleep keeps always-on logic but drops pin output enables; low-power timer timeout wakes.
// - Retention registers hold their contents through deep sleep until active.
// - Reset sources: power-on, brown-out, watchdog, software, low pin, wakeup.
// - Power-on resets every block; digital power-on and watchdog reset every block but always-on.
// - One 32-bit timer and 16-bit retention words; only power-on reset clears the words, power-on or a sleep or shutdown request the timer.
// - Wakeup repowers the digital domain, then runs the full reset procedure.
// - Applying the USB supply also wakes the device from deep sleep.
// - In deep sleep any level change on an enabled wake pin wakes.
// - In shutdown a low shared reset pin, or enabled wake pins, wake.
// - At most two other pins may be shutdown wake sources at once.
// - Eleven pins, each input or output, each with an alternate function.
// - Crystal clock goes out on a pin divided by 2, 4, 8, 16 or 32.
// - Clock sources restricted per block: processor, PWM, watchdog, slow timers.
// - A test mode runs built-in self-test; not entered in normal operation.
// - Low-power timer ticks at 125 Hz and runs while the processor is off.
module pmrs_sequencer
    import pmrs_pkg::*;
#(
    parameter int LP_TICK_DIV = LP_TICK_CYCLES,
    parameter int RESET_HOLD  = RESET_HOLD_CYC,
    parameter int REPOWER     = REPOWER_CYC
) (
    // Clock and power-on reset
    input  wire logic                      sys_clk,
    input  wire logic                      rst_n,
    // Reset sources
    input  wire logic                      brown_out,
    input  wire logic                      watchdog_expired,
    input  wire logic                      sw_reset_req,
    input  wire logic                      usb_supply_input,
    // Software control
    input  wire logic                      sw_shutdown_req,
    input  wire logic                      sw_sleep_req,
    input  wire logic                      test_mode_req,
    input  wire logic                      bist_done,
    input  wire logic [31:0]               sleep_timeout,
    input  wire logic                      sleep_timer_en,
    input  wire logic [GPIO_COUNT-1:0]     sleep_wake_en,
    input  wire logic [GPIO_COUNT-1:0]     shutdown_wake_en,
    // Retention write port
    input  wire logic                      retain_we,
    input  wire logic [1:0]                retain_addr,
    input  wire logic [RETAIN_W-1:0]       retain_wdata,
    // Clock selection and output
    input  wire logic                      crystal_clock,
    input  wire logic [2:0]                clk_out_div_sel,
    input  wire logic                      clk_out_en,
    input  wire logic                      cpu_clk_sel,
    input  wire logic                      pwm_clk_sel,
    input  wire logic                      slow_timer_clk_sel,
    // General-purpose pins
    input  wire logic [GPIO_COUNT-1:0]     gpio_in,
    input  wire logic [GPIO_COUNT-1:0]     gpio_dir_out,
    input  wire logic [GPIO_COUNT-1:0]     gpio_alt_sel,
    input  wire logic [GPIO_COUNT-1:0]     gpio_sw_out,
    input  wire logic [GPIO_COUNT-1:0]     gpio_alt_out,
    input  wire logic                      shared_reset_wake_pin,
    // Pin drive
    output logic [GPIO_COUNT-1:0]          gpio_out,
    output logic [GPIO_COUNT-1:0]          gpio_oe,
    output logic [GPIO_COUNT-1:0]          gpio_sync_in,
    output logic                           clock_output_pin,
    // Domain control and status
    output logic                           digital_reset_n,
    output logic                           digital_power_on,
    output logic                           bist_run,
    output pmrs_mode_t                     mode,
    output pmrs_cause_t                    reset_cause,
    output logic                           shutdown_cfg_err,
    output logic [TIMER_W-1:0]             aon_timer,
    output logic [RETAIN_W*RETAIN_COUNT-1:0] retain_rdata,
    output pmrs_clk_t                      cpu_clk_src,
    output pmrs_clk_t                      pwm_clk_src,
    output pmrs_clk_t                      wdt_clk_src,
    output pmrs_clk_t                      slow_timer_clk_src
);
    import pmrs_pkg::*;

    // Three-stage pin synchronisers; stage 1 feeds only stage 2
    logic [GPIO_COUNT+3:0] sync1;
    logic [GPIO_COUNT+3:0] sync2;
    logic [GPIO_COUNT+3:0] sync3;
    logic [GPIO_COUNT+3:0] pin_state;
    always_ff @(posedge sys_clk) begin
        sync1 <= {crystal_clock, usb_supply_input, shared_reset_wake_pin, brown_out, gpio_in};
        sync2 <= sync1;
        sync3 <= sync2;
        if (!rst_n) begin
            pin_state <= {4'h2, {GPIO_COUNT{1'b0}}};
        end else begin
            for (int i = 0; i < GPIO_COUNT + 4; i++) begin
                if (sync2[i] == sync3[i]) begin
                    pin_state[i] <= sync3[i];
                end
            end
        end
    end

    logic [GPIO_COUNT-1:0] gpio_q;
    logic                  ext_pin_q;
    logic                  brown_q;
    logic                  usb_q;
    logic                  xtal_q;
    assign gpio_q    = pin_state[GPIO_COUNT-1:0];
    assign brown_q   = pin_state[GPIO_COUNT];
    assign ext_pin_q = pin_state[GPIO_COUNT+1];
    assign usb_q     = pin_state[GPIO_COUNT+2];
    assign xtal_q    = pin_state[GPIO_COUNT+3];

    logic [GPIO_COUNT-1:0] gpio_prev;
    logic                  usb_prev;
    logic                  xtal_prev;
    always_ff @(posedge sys_clk) begin
        gpio_prev <= gpio_q;
        usb_prev  <= usb_q;
        xtal_prev <= xtal_q;
    end

    // Count enabled shutdown wake pins; more than two is a configuration error
    logic [3:0] shut_en_count;
    always_comb begin
        shut_en_count = 4'h0;
        for (int i = 0; i < GPIO_COUNT; i++) begin
            shut_en_count = shut_en_count + {3'h0, shutdown_wake_en[i]};
        end
    end
    logic shut_cfg_bad;
    assign shut_cfg_bad = shut_en_count > 4'(SHUT_WAKE_MAX);

    // 125 Hz tick for the low-power timer
    logic [31:0] tick_cnt;
    logic        lp_tick;
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            tick_cnt <= 32'h0000_0000;
            lp_tick  <= 1'b0;
        end else if (tick_cnt == 32'(LP_TICK_DIV - 1)) begin
            tick_cnt <= 32'h0000_0000;
            lp_tick  <= 1'b1;
        end else begin
            tick_cnt <= tick_cnt + 32'h0000_0001;
            lp_tick  <= 1'b0;
        end
    end

    // Wake and reset decoding
    logic sleep_pin_wake;
    logic sleep_usb_wake;
    logic sleep_timer_wake;
    logic shut_wake;
    logic soft_reset_src;
    assign sleep_pin_wake   = |((gpio_q ^ gpio_prev) & sleep_wake_en);
    assign sleep_usb_wake   = usb_q && !usb_prev;
    assign sleep_timer_wake = sleep_timer_en && (aon_timer >= sleep_timeout);
    assign shut_wake        = !ext_pin_q || (!shut_cfg_bad && |(gpio_q & shutdown_wake_en));
    assign soft_reset_src   = brown_q || watchdog_expired || sw_reset_req || !ext_pin_q;

    // Mode sequencer
    logic [15:0] seq_cnt;
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            mode             <= PMRS_MODE_RESET;
            seq_cnt          <= 16'h0000;
            reset_cause      <= PMRS_CAUSE_POWER_ON;
            digital_reset_n  <= 1'b0;
            digital_power_on <= 1'b1;
            bist_run         <= 1'b0;
        end else begin
            case (mode)
                PMRS_MODE_RESET: begin
                    digital_reset_n <= 1'b0;
                    if (seq_cnt == 16'(RESET_HOLD - 1)) begin
                        seq_cnt         <= 16'h0000;
                        digital_reset_n <= 1'b1;
                        if (reset_cause == PMRS_CAUSE_WAKE_SLEEP || reset_cause == PMRS_CAUSE_WAKE_SHUTDOWN) begin
                            mode <= PMRS_MODE_ACTIVE;
                        end else begin
                            mode             <= PMRS_MODE_DEEP_SLEEP;
                            digital_power_on <= 1'b0;
                        end
                    end else begin
                        seq_cnt <= seq_cnt + 16'h0001;
                    end
                end
                PMRS_MODE_DEEP_SLEEP: begin
                    if (sleep_pin_wake || sleep_usb_wake || sleep_timer_wake) begin
                        mode             <= PMRS_MODE_REPOWER;
                        reset_cause      <= PMRS_CAUSE_WAKE_SLEEP;
                        digital_power_on <= 1'b1;
                    end
                end
                PMRS_MODE_SHUTDOWN: begin
                    if (shut_wake) begin
                        mode             <= PMRS_MODE_REPOWER;
                        reset_cause      <= PMRS_CAUSE_WAKE_SHUTDOWN;
                        digital_power_on <= 1'b1;
                    end
                end
                PMRS_MODE_REPOWER: begin
                    digital_reset_n <= 1'b0; // Held in reset while the supply settles
                    if (seq_cnt == 16'(REPOWER - 1)) begin
                        seq_cnt <= 16'h0000;
                        mode    <= PMRS_MODE_RESET;
                    end else begin
                        seq_cnt <= seq_cnt + 16'h0001;
                    end
                end
                PMRS_MODE_ACTIVE: begin
                    if (soft_reset_src) begin
                        mode            <= PMRS_MODE_RESET;
                        digital_reset_n <= 1'b0;
                        if (brown_q) begin
                            reset_cause <= PMRS_CAUSE_BROWN_OUT;
                        end else if (watchdog_expired) begin
                            reset_cause <= PMRS_CAUSE_WATCHDOG;
                        end else if (!ext_pin_q) begin
                            reset_cause <= PMRS_CAUSE_EXT_PIN;
                        end else begin
                            reset_cause <= PMRS_CAUSE_SOFTWARE;
                        end
                    end else if (sw_shutdown_req) begin
                        mode             <= PMRS_MODE_SHUTDOWN;
                        digital_power_on <= 1'b0;
                    end else if (sw_sleep_req) begin
                        mode             <= PMRS_MODE_DEEP_SLEEP;
                        digital_power_on <= 1'b0;
                    end else if (test_mode_req) begin
                        mode     <= PMRS_MODE_TEST;
                        bist_run <= 1'b1;
                    end
                end
                PMRS_MODE_TEST: begin
                    if (bist_done) begin
                        mode     <= PMRS_MODE_ACTIVE;
                        bist_run <= 1'b0;
                    end
                end
                default: begin
                    mode <= PMRS_MODE_RESET;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            shutdown_cfg_err <= 1'b0;
        end else begin
            shutdown_cfg_err <= shut_cfg_bad;
        end
    end

    // Always-on timer: cleared by power-on reset and restarted by a sleep or shutdown request while active
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            aon_timer <= TIMER_RESET;
        end else if (mode == PMRS_MODE_ACTIVE && (sw_sleep_req || sw_shutdown_req)) begin
            aon_timer <= TIMER_RESET;
        end else if (lp_tick && aon_timer != 32'hFFFF_FFFF) begin
            aon_timer <= aon_timer + 32'h0000_0001;
        end
    end

    // Retention words: writable only while active, kept across every other reset
    logic [RETAIN_W-1:0] retain_mem [RETAIN_COUNT];
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            for (int i = 0; i < RETAIN_COUNT; i++) begin
                retain_mem[i] <= RETAIN_RESET;
            end
        end else if (retain_we && mode == PMRS_MODE_ACTIVE) begin
            retain_mem[retain_addr] <= retain_wdata;
        end
    end
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            retain_rdata <= '0;
        end else begin
            for (int i = 0; i < RETAIN_COUNT; i++) begin
                retain_rdata[i*RETAIN_W +: RETAIN_W] <= retain_mem[i];
            end
        end
    end

    // Pin drive; the divided crystal clock goes out on clock_output_pin, not on a general-purpose pin
    logic [4:0] xtal_div;
    logic       clk_div_out;
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            xtal_div    <= 5'h00;
            clk_div_out <= 1'b0;
        end else begin
            if (xtal_q && !xtal_prev) begin
                xtal_div <= xtal_div + 5'h01;
            end
            clk_div_out <= clk_out_en && xtal_div[clk_out_div_sel > 3'h4 ? 3'h4 : clk_out_div_sel];
        end
    end
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            gpio_out         <= '0;
            gpio_oe          <= '0;
            gpio_sync_in     <= '0;
            clock_output_pin <= 1'b0;
        end else begin
            gpio_oe          <= digital_power_on ? gpio_dir_out : '0;
            gpio_out         <= (gpio_alt_sel & gpio_alt_out) | (~gpio_alt_sel & gpio_sw_out);
            gpio_sync_in     <= gpio_q;
            clock_output_pin <= clk_div_out;
        end
    end

    // Clock source selection limited per block
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            cpu_clk_src        <= PMRS_CLK_XTAL;
            pwm_clk_src        <= PMRS_CLK_XTAL;
            wdt_clk_src        <= PMRS_CLK_DIV32K;
            slow_timer_clk_src <= PMRS_CLK_RING;
        end else begin
            cpu_clk_src        <= cpu_clk_sel ? PMRS_CLK_PLL : PMRS_CLK_XTAL;
            pwm_clk_src        <= pwm_clk_sel ? PMRS_CLK_DIV32K : PMRS_CLK_XTAL;
            wdt_clk_src        <= PMRS_CLK_DIV32K;
            slow_timer_clk_src <= slow_timer_clk_sel ? PMRS_CLK_DIV32K : PMRS_CLK_RING;
        end
    end

    // Checks
    sleep_after_reset_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (mode == PMRS_MODE_RESET && seq_cnt == 16'(RESET_HOLD - 1) && reset_cause == PMRS_CAUSE_POWER_ON)
        |=> mode == PMRS_MODE_DEEP_SLEEP) else $error("reset did not enter deep sleep");
    shutdown_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (mode == PMRS_MODE_SHUTDOWN && !shut_wake) |=> mode == PMRS_MODE_SHUTDOWN)
        else $error("shutdown left without wake");
    timer_wake_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (mode == PMRS_MODE_DEEP_SLEEP && sleep_timer_wake) |=> mode == PMRS_MODE_REPOWER)
        else $error("timer did not wake");
    retain_keep_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (mode != PMRS_MODE_ACTIVE) |=> $stable(retain_mem[0])) else $error("retention lost");
    wake_repower_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $rose(mode == PMRS_MODE_REPOWER) |-> digital_power_on ##[1:300] mode == PMRS_MODE_RESET)
        else $error("repower did not lead to reset");
    usb_wake_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (mode == PMRS_MODE_DEEP_SLEEP && sleep_usb_wake) |=> reset_cause == PMRS_CAUSE_WAKE_SLEEP)
        else $error("usb did not wake");
    ext_reset_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (mode == PMRS_MODE_ACTIVE && !ext_pin_q && !brown_q && !watchdog_expired)
        |=> (!digital_reset_n && reset_cause == PMRS_CAUSE_EXT_PIN))
        else $error("external reset missed");
    shut_limit_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (mode == PMRS_MODE_SHUTDOWN && shut_cfg_bad && ext_pin_q) |=> mode == PMRS_MODE_SHUTDOWN)
        else $error("bad wake config woke");
    tick_rate_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        lp_tick |=> !lp_tick) else $error("tick too wide");
endmodule // pmrs_sequencer

/* src/pmrs_pkg.sv */
// Package for the power-mode and reset sequencer: modes, causes, field widths and timing counts.
// Assumes a single 100 MHz system clock; slower rates come from enable pulses.
package pmrs_pkg;
    localparam int  CLK_HZ           = 100_000_000;
    localparam int  LP_TICK_HZ       = 125;
    localparam int  LP_TICK_CYCLES   = CLK_HZ / LP_TICK_HZ;
    localparam int  RESET_HOLD_NS    = 1000;
    localparam int  RESET_HOLD_CYC   = (RESET_HOLD_NS + 9) / 10;
    localparam int  REPOWER_NS       = 500;
    localparam int  REPOWER_CYC      = (REPOWER_NS + 9) / 10;
    localparam int  GPIO_COUNT       = 11;
    localparam int  TIMER_W          = 32;
    localparam int  RETAIN_W         = 16;
    localparam int  RETAIN_COUNT     = 4;
    localparam int  SHUT_WAKE_MAX    = 2;
    localparam logic [2:0] DIV_SEL_RESET = 3'h0;
    localparam logic [15:0] RETAIN_RESET = 16'h0000;
    localparam logic [31:0] TIMER_RESET  = 32'h0000_0000;

    typedef enum logic [1:0] {PMRS_CLK_XTAL, PMRS_CLK_PLL, PMRS_CLK_DIV32K, PMRS_CLK_RING} pmrs_clk_t;

    typedef enum logic [2:0] {
        PMRS_CAUSE_POWER_ON, PMRS_CAUSE_BROWN_OUT, PMRS_CAUSE_WATCHDOG, PMRS_CAUSE_SOFTWARE,
        PMRS_CAUSE_EXT_PIN, PMRS_CAUSE_WAKE_SLEEP, PMRS_CAUSE_WAKE_SHUTDOWN
    } pmrs_cause_t;

    typedef enum logic [2:0] {
        PMRS_MODE_RESET, PMRS_MODE_DEEP_SLEEP, PMRS_MODE_SHUTDOWN, PMRS_MODE_REPOWER,
        PMRS_MODE_ACTIVE, PMRS_MODE_TEST
    } pmrs_mode_t;
endpackage

/* test/pmrs_pin_driver.sv */
// Board-side model of the circuitry that drives the wake pins, the shared reset pin and the USB supply.
// Assumes the bench calls its tasks; every pin change lands on a falling edge of sys_clk.
module pmrs_pin_driver
    import pmrs_pkg::*;
(
    // Clock
    input  wire logic                 sys_clk,
    // Driven pins
    output logic [GPIO_COUNT-1:0]     gpio_in,
    output logic                      shared_reset_wake_pin,
    output logic                      usb_supply_input
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        gpio_in               = '0;
        shared_reset_wake_pin = 1'b1;   // Idles high, the reset input is active low
        usb_supply_input      = 1'b0;
    end

    // One level change on one pin, which is what a deep-sleep wake watches for
    task automatic toggle_pin(input int idx);
        @(negedge sys_clk);
        gpio_in[idx] = ~gpio_in[idx];
    endtask

    // Held low long enough to pass the input synchroniser
    task automatic hold_reset(input int cycles);
        @(negedge sys_clk);
        shared_reset_wake_pin = 1'b0;
        repeat (cycles) @(negedge sys_clk);
        shared_reset_wake_pin = 1'b1;
    endtask

    task automatic apply_usb();
        @(negedge sys_clk);
        usb_supply_input = 1'b1;
    endtask
endmodule // pmrs_pin_driver

/* test/power_mode_reset_sequencer_test.sv */
// Self-checking bench for the sequencer: modes, wakes, reset sources, retention, pins and clocks.
// Assumes shortened counts via parameters; requests change on falling edges of sys_clk.
module power_mode_reset_sequencer_test import pmrs_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic                  sys_clk = 1'b0, rst_n = 1'b0, crystal_clock = 1'b0;
    logic                  brown_out = 1'b0, watchdog_expired = 1'b0, sw_reset_req = 1'b0, sw_shutdown_req = 1'b0;
    logic                  sw_sleep_req = 1'b0, test_mode_req = 1'b0, bist_done = 1'b0;
    logic                  sleep_timer_en = 1'b0, retain_we = 1'b0, clk_out_en = 1'b0;
    logic                  cpu_clk_sel = 1'b0, pwm_clk_sel = 1'b0, slow_timer_clk_sel = 1'b0;
    logic [31:0]           sleep_timeout = 32'h0;
    logic [1:0]            retain_addr = 2'h0;
    logic [2:0]            clk_out_div_sel = 3'h0;
    logic [15:0]           retain_wdata = 16'h0;
    logic [GPIO_COUNT-1:0] sleep_wake_en = '0, shutdown_wake_en = '0, gpio_dir_out = '0;
    logic [GPIO_COUNT-1:0] gpio_alt_sel = '0, gpio_sw_out = '0, gpio_alt_out = '0;
    logic [GPIO_COUNT-1:0] gpio_in, gpio_out, gpio_oe, gpio_sync_in;
    logic                  shared_reset_wake_pin, usb_supply_input, clock_output_pin, digital_reset_n;
    logic                  digital_power_on, bist_run, shutdown_cfg_err;
    pmrs_mode_t            mode;
    pmrs_cause_t           reset_cause;
    pmrs_clk_t             cpu_clk_src, pwm_clk_src, wdt_clk_src, slow_timer_clk_src;
    logic [31:0]           aon_timer;
    logic [63:0]           retain_rdata;
    longint                t0 = 0, t1 = 0;
    int                    mismatches = 0;
    int                    compares = 0;
    int                    rst_edges = 0;
    int                    rst_mark = 0;
    pmrs_cause_t causes [4] = '{PMRS_CAUSE_WATCHDOG, PMRS_CAUSE_SOFTWARE, PMRS_CAUSE_BROWN_OUT, PMRS_CAUSE_EXT_PIN};

    always #5 sys_clk = ~sys_clk;
    // Crystal edges land on sys_clk falling edges so the divided period is exact
    always #40 crystal_clock = ~crystal_clock;
    always @(posedge sys_clk) if (digital_reset_n === 1'b0) rst_edges <= rst_edges + 1;
    always @(posedge clock_output_pin) begin
        t0 = t1;
        t1 = $time;
    end

    pmrs_pin_driver pmrs_pin_driver_i (.sys_clk, .gpio_in, .shared_reset_wake_pin, .usb_supply_input);
    pmrs_sequencer #(.LP_TICK_DIV(4), .RESET_HOLD(4), .REPOWER(3)) pmrs_sequencer_i (
        .sys_clk, .rst_n, .brown_out, .watchdog_expired, .sw_reset_req, .usb_supply_input, .sw_shutdown_req,
        .sw_sleep_req, .test_mode_req, .bist_done, .sleep_timeout, .sleep_timer_en, .sleep_wake_en,
        .shutdown_wake_en,
        .retain_we, .retain_addr, .retain_wdata, .crystal_clock, .clk_out_div_sel, .clk_out_en,
        .cpu_clk_sel, .pwm_clk_sel, .slow_timer_clk_sel, .gpio_in, .gpio_dir_out, .gpio_alt_sel,
        .gpio_sw_out, .gpio_alt_out, .shared_reset_wake_pin, .gpio_out, .gpio_oe, .gpio_sync_in,
        .clock_output_pin, .digital_reset_n, .digital_power_on, .bist_run, .mode, .reset_cause,
        .shutdown_cfg_err, .aon_timer, .retain_rdata, .cpu_clk_src, .pwm_clk_src, .wdt_clk_src,
        .slow_timer_clk_src);

    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic cyc(input int k);
        repeat (k) @(negedge sys_clk);
    endtask

    // Request lines by number: watchdog, software reset, brown-out, shutdown, sleep, test, self-test done
    task automatic set_req(input int b, input logic v);
        case (b)
            0: watchdog_expired = v;
            1: sw_reset_req = v;
            2: brown_out = v;
            3: sw_shutdown_req = v;
            4: sw_sleep_req = v;
            5: test_mode_req = v;
            default: bist_done = v;
        endcase
    endtask

    task automatic pulse(input int b, input int k);
        set_req(b, 1'b1);
        cyc(k);
        set_req(b, 1'b0);
    endtask

    task automatic wait_mode(input pmrs_mode_t m, input int lim);
        int k;
        k = 0;
        while (mode !== m && k < lim) begin
            cyc(1);
            k++;
        end
        chk(mode, m);
    endtask

    // A reset may end in deep sleep; a pin change then brings the device back
    task automatic to_active();
        cyc(12);
        if (mode !== PMRS_MODE_ACTIVE) pmrs_pin_driver_i.toggle_pin(3);
        wait_mode(PMRS_MODE_ACTIVE, 40);
    endtask

    task automatic wrap_up();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    initial begin
        cyc(8);
        chk(mode, PMRS_MODE_RESET);
        chk(reset_cause, PMRS_CAUSE_POWER_ON);
        chk(aon_timer, 64'h0);
        chk(retain_rdata, 64'h0);
        rst_n = 1'b1;
        wait_mode(PMRS_MODE_DEEP_SLEEP, 20);
        chk(digital_power_on, 1'b0);
        pmrs_pin_driver_i.toggle_pin(5);
        cyc(20);
        chk(mode, PMRS_MODE_DEEP_SLEEP);
        $display("test reset_to_sleep done");
        sleep_wake_en = 11'h008;
        pmrs_pin_driver_i.toggle_pin(3);
        wait_mode(PMRS_MODE_REPOWER, 10);
        chk(digital_power_on, 1'b1);
        wait_mode(PMRS_MODE_RESET, 10);
        chk(digital_reset_n, 1'b0);
        wait_mode(PMRS_MODE_ACTIVE, 10);
        chk(reset_cause, PMRS_CAUSE_WAKE_SLEEP);
        chk(bist_run, 1'b0);
        $display("test gpio_wake done");
        for (int i = 0; i < RETAIN_COUNT; i++) begin
            retain_addr  = i[1:0];
            retain_wdata = 16'hA5C0 + 16'(i);
            retain_we    = 1'b1;
            cyc(1);
        end
        retain_we      = 1'b0;
        sleep_timeout  = 32'h3;
        sleep_timer_en = 1'b1;
        pulse(4, 1);
        wait_mode(PMRS_MODE_DEEP_SLEEP, 5);
        wait_mode(PMRS_MODE_ACTIVE, 100);
        chk(aon_timer >= 32'h3, 1'b1);
        chk(retain_rdata, 64'hA5C3_A5C2_A5C1_A5C0);
        sleep_timer_en = 1'b0;
        pulse(4, 1);
        wait_mode(PMRS_MODE_DEEP_SLEEP, 5);
        pmrs_pin_driver_i.apply_usb();
        wait_mode(PMRS_MODE_ACTIVE, 40);
        $display("test sleep_wakes done");
        for (int k = 0; k < 4; k++) begin
            rst_mark = rst_edges;
            if (k == 3) pmrs_pin_driver_i.hold_reset(8);
            else pulse(k, (k == 2) ? 8 : 1);
            cyc(12);
            chk(rst_edges > rst_mark, 1'b1);
            chk(reset_cause, causes[k]);
            chk(retain_rdata, 64'hA5C3_A5C2_A5C1_A5C0);
            to_active();
        end
        $display("test reset_sources done");
        shutdown_wake_en = 11'h007;
        pulse(3, 1);
        wait_mode(PMRS_MODE_SHUTDOWN, 5);
        pmrs_pin_driver_i.toggle_pin(0);
        pulse(4, 1);
        cyc(20);
        chk(mode, PMRS_MODE_SHUTDOWN);
        chk(shutdown_cfg_err, 1'b1);
        chk(gpio_oe, 11'h000);
        pmrs_pin_driver_i.hold_reset(6);
        wait_mode(PMRS_MODE_ACTIVE, 40);
        chk(reset_cause, PMRS_CAUSE_WAKE_SHUTDOWN);
        shutdown_wake_en = 11'h006;
        cyc(2);
        chk(shutdown_cfg_err, 1'b0);
        pulse(3, 1);
        wait_mode(PMRS_MODE_SHUTDOWN, 5);
        pmrs_pin_driver_i.toggle_pin(2);
        wait_mode(PMRS_MODE_ACTIVE, 40);
        chk(reset_cause, PMRS_CAUSE_WAKE_SHUTDOWN);
        $display("test shutdown done");
        gpio_dir_out = 11'h7FF;
        gpio_sw_out  = 11'h2A5;
        gpio_alt_out = 11'h15A;
        cyc(3);
        chk(gpio_oe, 11'h7FF);
        chk(gpio_out, 11'h2A5);
        chk(gpio_sync_in, gpio_in);
        gpio_alt_sel = 11'h0F0;
        gpio_dir_out = 11'h00F;
        cyc(3);
        chk(gpio_out, 11'h255);
        chk(gpio_oe, 11'h00F);
        for (int s = 0; s < 2; s++) begin
            {cpu_clk_sel, pwm_clk_sel, slow_timer_clk_sel} = {3{s[0]}};
            cyc(3);
            chk(cpu_clk_src, s[0] ? PMRS_CLK_PLL : PMRS_CLK_XTAL);
            chk(pwm_clk_src, s[0] ? PMRS_CLK_DIV32K : PMRS_CLK_XTAL);
            chk(wdt_clk_src, PMRS_CLK_DIV32K);
            chk(slow_timer_clk_src, s[0] ? PMRS_CLK_DIV32K : PMRS_CLK_RING);
        end
        clk_out_en = 1'b1;
        for (int s = 0; s < 5; s++) begin
            clk_out_div_sel = s[2:0];
            cyc(600);
            chk(64'(t1 - t0), 64'(160 << s));
        end
        $display("test pins_and_clocks done");
        pulse(5, 1);
        wait_mode(PMRS_MODE_TEST, 5);
        chk(bist_run, 1'b1);
        pulse(6, 1);
        cyc(3);
        chk(bist_run, 1'b0);
        $display("test test_mode done");
        wrap_up();
    end

    // The sequence needs well under 10000 cycles
    initial begin
        #200000;
        mismatches++;
        $display("[ERR] %0t run did not finish in time", $time);
        wrap_up();
    end
endmodule // power_mode_reset_sequencer_test
